//--- src/ilr_pkg.sv
// Shared constants and carriers for the lock and soft reset register logic.
package ilr_pkg;

  // Register offsets as seen by the serial interface decoder.
  localparam logic [7:0] ADDR_SUPPLY_FAULT = 8'h02; // Supply fault status.
  localparam logic [7:0] ADDR_CHIP_TEMP    = 8'h0E; // Chip temperature.
  localparam logic [7:0] ADDR_WLC          = 8'h10; // Write lock control.

  // Field positions inside the write lock control register.
  localparam int LOCK_BIT = 7; // Init done lock bit.
  localparam int DIS_BIT  = 3; // Supply error report disable bit.
  localparam int KEY_LSB  = 0; // Lowest restart key bit.
  localparam int KEY_W    = 2; // Width of the restart key field.

  // Restart key values of the three writes, in order.
  localparam logic [1:0] KEY_STEP1 = 2'h0; // First write, both bits low.
  localparam logic [1:0] KEY_STEP2 = 2'h3; // Second write, both bits high.
  localparam logic [1:0] KEY_STEP3 = 2'h2; // Third write, only bit one high.
  localparam logic [1:0] KEY_READ  = 2'h0; // Key field as seen on a read.

  // Reset values.
  localparam logic [7:0] WLC_RST  = 8'h00; // Write lock control at reset.
  localparam logic [7:0] TEMP_RST = 8'h00; // Chip temperature at reset.
  localparam logic [7:0] KEY_MASK = 8'h03; // Key bits, kept out of the check.
  localparam logic [7:0] CHK_RST  = 8'h00; // Check code at reset.

  // Width of the check code.
  localparam int CHK_W = 8;

  // Register access request from the serial interface decoder.
  typedef struct packed {
    logic       write; // One for a write, zero for a read.
    logic [7:0] addr;  // Register offset.
    logic [7:0] wdata; // Write data.
  } ilr_req_s;

  // Register access response back to the serial interface.
  typedef struct packed {
    logic       err_code; // Send the sensor data error code instead.
    logic [7:0] data;     // Register contents returned.
  } ilr_rsp_s;

  // Progress through the restart key sequence.
  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_GOT1,
    KEY_GOT2
  } ilr_key_e;

endpackage

//--- src/ilr_regs.sv
`timescale 1ns/1ns
// Contract
// RQ1: Read-only chip temperature register, resets to zero.
// RQ2: Init done lock is bit seven, set by write.
// RQ3: Lock set blocks writes outside write lock control.
// RQ4: Lock set lets only restart key bits change.
// RQ5: Lock stays set until device reset.
// RQ6: Lock set starts continuous check code comparison.
// RQ7: Lock set disables and refuses self-test start.
// RQ8: SPI, disable low: hold, then one error code.
// RQ9: SPI, disable low: clear on read/transmit when zero.
// RQ10: SPI, disable high: silent, clear at timer zero.
// RQ11: I2C: silent until expiry, clear only by read.
// RQ12: Host writes keys 00, 11, then 01; the code takes 10 as the third key.
// RQ13: Soft reset only on exact third key write.
// RQ14: Write response returns newly written contents with keys.
// RQ15: Third key write gets no response or acknowledge.
// RQ16: Read returns 00 keys and aborts key sequence.
// RQ17: Restart key bits excluded from the check code.
// RQ18: One shared timer, reloaded while supply error present.
// RQ19: Temperature and timer state come from outside.
module ilr_regs
#(
  parameter int USER_W = 64 // Width of the other user writable registers.
)
(
  input  wire logic             clock_i,          // System clock, 100 MHz.
  input  wire logic             sys_rst_i,        // Asynchronous reset, high.
  input  wire logic             ce_i,             // Clock enable.
  input  wire logic             spi_mode_i,       // One for SPI, zero for I2C.
  input  wire logic             req_valid_i,      // Register access strobe.
  input  wire ilr_pkg::ilr_req_s req_i,           // Register access request.
  input  wire logic             data_tx_i,        // Status data transmission.
  input  wire logic [7:0]       temp_i,           // Measured temperature.
  input  wire logic             sup_err_i,        // Supply error present.
  input  wire logic             timer_zero_i,     // Supply timer at zero.
  input  wire logic [USER_W-1:0] user_regs_i,     // Other writable registers.
  input  wire logic             selftest_req_i,   // Self-test start request.
  output logic                  rsp_valid_o,      // Response strobe.
  output ilr_pkg::ilr_rsp_s     rsp_o,            // Response contents.
  output logic                  no_ack_o,         // Withhold acknowledge.
  output logic                  hold_rsp_o,       // No responses allowed.
  output logic                  user_wr_en_o,     // Other registers writable.
  output logic                  lock_o,           // Init done lock state.
  output logic                  sup_fault_o,      // Supply error flag.
  output logic                  chk_err_o,        // Check code mismatch seen.
  output logic                  selftest_start_o, // Self-test start granted.
  output logic                  soft_reset_o      // Soft reset pulse.
);

  // Refuse widths that do not fold into whole bytes.
  if (USER_W % ilr_pkg::CHK_W != 0 || USER_W < ilr_pkg::CHK_W)
  begin : g_width_check
    $error("USER_W must be a positive multiple of the check width.");
  end

  // Stored register state.
  logic [7:0]        wlc_ff;       // Write lock control contents.
  logic [7:0]        temp_ff;      // Chip temperature contents.
  logic              sup_ff;       // Supply error flag.
  logic              ecode_ff;     // Error code response still owed.
  logic              srst_ff;      // Soft reset in progress.
  logic              chk_err_ff;   // Sticky check code mismatch.
  logic              lock_d_ff;    // Lock state one cycle earlier.
  logic [ilr_pkg::CHK_W-1:0] chk_prev_ff; // Previously computed code.
  ilr_pkg::ilr_key_e key_ff;       // Key sequence progress.
  ilr_pkg::ilr_rsp_s rsp_ff;       // Registered response.
  logic              rsp_v_ff;     // Registered response strobe.

  // Next values.
  logic [7:0]        nxt_wlc;
  logic              nxt_sup;
  logic              nxt_ecode;
  ilr_pkg::ilr_key_e nxt_key;
  logic [ilr_pkg::CHK_W-1:0] nxt_chk;

  // Access decode.
  wire logic       lock    = wlc_ff[ilr_pkg::LOCK_BIT];
  wire logic       dis     = wlc_ff[ilr_pkg::DIS_BIT];
  wire logic       wr_acc  = req_valid_i && req_i.write;
  wire logic       rd_acc  = req_valid_i && !req_i.write;
  wire logic       wr_wlc  = wr_acc && req_i.addr == ilr_pkg::ADDR_WLC;
  wire logic       rd_sup  = rd_acc &&
                             req_i.addr == ilr_pkg::ADDR_SUPPLY_FAULT;
  wire logic [1:0] wr_key  = req_i.wdata[ilr_pkg::KEY_LSB +: ilr_pkg::KEY_W];
  wire logic       key_hit = wr_wlc && key_ff == ilr_pkg::KEY_GOT2 &&
                             wr_key == ilr_pkg::KEY_STEP3;

  // Locked writes only reach the key bits; the lock bit never falls.
  assign nxt_wlc = !wr_wlc ? wlc_ff :
                   lock    ? ((wlc_ff & ~ilr_pkg::KEY_MASK) |
                              (req_i.wdata & ilr_pkg::KEY_MASK)) : // RQ4
                             (req_i.wdata |
                              (wlc_ff & (8'h01 << ilr_pkg::LOCK_BIT))); // RQ5

  // Writes to the other user registers are cut off by the lock.
  assign user_wr_en_o = !lock; // RQ3

  // Read data before the key field is masked.
  wire logic [7:0] rd_raw = req_i.addr == ilr_pkg::ADDR_CHIP_TEMP ? temp_ff :
                            req_i.addr == ilr_pkg::ADDR_WLC ? wlc_ff :
                            8'h00;
  // A read always shows zeros in the key field.
  wire logic [7:0] rd_data = req_i.addr == ilr_pkg::ADDR_WLC ?
                             {rd_raw[7:2], ilr_pkg::KEY_READ} : rd_raw; // RQ16

  // A write answers with the contents it leaves behind, keys included.
  wire logic [7:0] wr_data = req_i.addr == ilr_pkg::ADDR_WLC ? nxt_wlc :
                             rd_raw; // RQ14

  // Key sequence: only three back to back writes of the right keys count.
  always_comb
  begin
    nxt_key = ilr_pkg::KEY_IDLE;
    if (!req_valid_i)
    begin
      // No access leaves the sequence where it is.
      nxt_key = key_ff;
    end
    else if (wr_wlc && wr_key == ilr_pkg::KEY_STEP1)
    begin
      // A first key always restarts the sequence.
      nxt_key = ilr_pkg::KEY_GOT1; // RQ13
    end
    else if (wr_wlc && key_ff == ilr_pkg::KEY_GOT1 &&
             wr_key == ilr_pkg::KEY_STEP2)
    begin
      // Second key only counts right after the first.
      nxt_key = ilr_pkg::KEY_GOT2; // RQ13
    end
    // Reads, other writes and wrong keys fall back to idle. RQ16
  end

  // Supply error flag: the present error wins over any clear except soft reset.
  always_comb
  begin
    nxt_sup   = sup_ff;
    nxt_ecode = ecode_ff;
    if (spi_mode_i && !dis)
    begin
      // Owe one error code response while the timer runs.
      if (sup_ff && !timer_zero_i)
      begin
        nxt_ecode = 1'b1; // RQ8
      end
      else if (timer_zero_i && (data_tx_i || req_valid_i))
      begin
        nxt_ecode = 1'b0; // RQ8
      end
      // Clears only once the timer has run out.
      if (timer_zero_i && (rd_sup || data_tx_i))
      begin
        nxt_sup = 1'b0; // RQ9
      end
    end
    else if (spi_mode_i)
    begin
      // Reporting disabled: the flag drops by itself at timer zero.
      nxt_ecode = 1'b0;
      if (timer_zero_i)
      begin
        nxt_sup = 1'b0; // RQ10
      end
    end
    else
    begin
      // Two-wire mode clears only on a read of the fault status.
      nxt_ecode = 1'b0;
      if (rd_sup)
      begin
        nxt_sup = 1'b0; // RQ11
      end
    end
    if (sup_err_i)
    begin
      nxt_sup = 1'b1; // RQ18
    end
  end

  // Check code folds the other user registers and the non-key bits.
  always_comb
  begin
    nxt_chk = wlc_ff[ilr_pkg::CHK_W-1:0] & ~ilr_pkg::KEY_MASK; // RQ17
    for (int i = 0; i < USER_W / ilr_pkg::CHK_W; i++)
    begin
      nxt_chk = {nxt_chk[ilr_pkg::CHK_W-2:0], nxt_chk[ilr_pkg::CHK_W-1]} ^
                user_regs_i[i*ilr_pkg::CHK_W +: ilr_pkg::CHK_W];
    end
  end

  // Any response is held while the shared timer runs.
  assign hold_rsp_o = !timer_zero_i; // RQ8 RQ10 RQ11

  // Register contents and soft reset.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wlc_ff  <= ilr_pkg::WLC_RST;
      temp_ff <= ilr_pkg::TEMP_RST;
      key_ff  <= ilr_pkg::KEY_IDLE;
      srst_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      if (srst_ff)
      begin
        // Soft reset returns the block to its reset contents.
        wlc_ff  <= ilr_pkg::WLC_RST; // RQ5
        temp_ff <= ilr_pkg::TEMP_RST;
        key_ff  <= ilr_pkg::KEY_IDLE;
        srst_ff <= 1'b0;
      end
      else
      begin
        wlc_ff  <= nxt_wlc; // RQ2
        temp_ff <= temp_i; // RQ1 RQ19
        key_ff  <= nxt_key;
        srst_ff <= key_hit; // RQ13
      end
    end
  end

  // Supply flag and owed error code.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sup_ff   <= 1'b0;
      ecode_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      sup_ff   <= srst_ff ? 1'b0 : nxt_sup;
      ecode_ff <= srst_ff ? 1'b0 : nxt_ecode;
    end
  end

  // Continuous check: each code is compared with the one before.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      chk_prev_ff <= ilr_pkg::CHK_RST;
      lock_d_ff   <= 1'b0;
      chk_err_ff  <= 1'b0;
    end
    else if (ce_i)
    begin
      chk_prev_ff <= nxt_chk;
      lock_d_ff   <= srst_ff ? 1'b0 : lock;
      if (srst_ff)
      begin
        chk_err_ff <= 1'b0;
      end
      else if (lock && lock_d_ff && nxt_chk != chk_prev_ff)
      begin
        chk_err_ff <= 1'b1; // RQ6
      end
    end
  end

  // Response register: the third key write gets no answer at all.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rsp_ff   <= '0;
      rsp_v_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      rsp_v_ff <= req_valid_i && !key_hit && !srst_ff &&
                  timer_zero_i; // RQ15
      if (req_valid_i)
      begin
        rsp_ff.data     <= req_i.write ? wr_data : rd_data;
        rsp_ff.err_code <= ecode_ff && spi_mode_i; // RQ8
      end
    end
  end

  // Outputs.
  assign rsp_valid_o      = rsp_v_ff;
  assign rsp_o            = rsp_ff;
  assign no_ack_o         = key_hit; // RQ15
  assign lock_o           = lock;
  assign sup_fault_o      = sup_ff;
  assign chk_err_o        = chk_err_ff;
  assign selftest_start_o = selftest_req_i && !lock; // RQ7
  assign soft_reset_o     = srst_ff;

  // First two key steps, the first key write followed by one idle cycle.
  sequence s_key12;
    ce_i && wr_wlc && wr_key == ilr_pkg::KEY_STEP1 && !srst_ff
    ##1 ce_i && !req_valid_i
    ##1 ce_i && wr_wlc && wr_key == ilr_pkg::KEY_STEP2;
  endsequence

  // Assertions.
  a_key_reset_fires: assert property (@(posedge clock_i) disable iff // RQ13
    (sys_rst_i) s_key12 ##1 ce_i && !req_valid_i ##1 ce_i && wr_wlc &&
    wr_key == ilr_pkg::KEY_STEP3 |=> soft_reset_o)
    else $error("Exact key sequence did not reset.");
  a_reset_needs_hit: assert property (@(posedge clock_i) disable iff // RQ13
    (sys_rst_i) $rose(soft_reset_o) |-> $past(key_hit))
    else $error("Soft reset without third key write.");
  a_read_aborts_key: assert property (@(posedge clock_i) disable iff // RQ16
    (sys_rst_i) ce_i && rd_acc |=> key_ff == ilr_pkg::KEY_IDLE)
    else $error("Read did not abort the key sequence.");
  a_read_key_zero: assert property (@(posedge clock_i) disable iff // RQ16
    (sys_rst_i) ce_i && rd_acc && req_i.addr == ilr_pkg::ADDR_WLC &&
    timer_zero_i && !srst_ff |=> rsp_valid_o && rsp_o.data[1:0] == 2'h0)
    else $error("Read returned nonzero key bits.");
  a_lock_stays_set: assert property (@(posedge clock_i) disable iff // RQ5
    (sys_rst_i) lock && !srst_ff |=> lock)
    else $error("Lock bit fell without reset.");
  a_lock_keys_only: assert property (@(posedge clock_i) disable iff // RQ4
    (sys_rst_i) lock && !srst_ff |=>
    (wlc_ff & ~ilr_pkg::KEY_MASK) == $past(wlc_ff & ~ilr_pkg::KEY_MASK))
    else $error("Locked write changed a non-key bit.");
  a_no_selftest: assert property (@(posedge clock_i) disable iff // RQ7
    (sys_rst_i) lock |-> !selftest_start_o && !user_wr_en_o)
    else $error("Self-test or write allowed under lock.");
  a_no_third_rsp: assert property (@(posedge clock_i) disable iff // RQ15
    (sys_rst_i) ce_i && key_hit |=> !rsp_valid_o)
    else $error("Third key write was answered.");
  a_write_echo: assert property (@(posedge clock_i) disable iff // RQ14
    (sys_rst_i) ce_i && wr_wlc && !lock && !key_hit && timer_zero_i &&
    !srst_ff |=> rsp_o.data == wlc_ff)
    else $error("Write response is not the new contents.");
  a_sup_set_wins: assert property (@(posedge clock_i) disable iff // RQ18
    (sys_rst_i) ce_i && sup_err_i && !srst_ff |=> sup_fault_o)
    else $error("Present supply error was cleared.");
  a_i2c_clear_read: assert property (@(posedge clock_i) disable iff // RQ11
    (sys_rst_i) ce_i && !spi_mode_i && sup_fault_o && !rd_sup && !srst_ff
    |=> sup_fault_o)
    else $error("Two-wire supply flag cleared without read.");

endmodule

//--- tb/ilr_host_model.sv
`timescale 1ns/1ns
// Host controller model that issues register accesses one at a time.
module ilr_host_model
(
  input  wire logic              clock_i,     // System clock.
  input  wire logic              rsp_valid_i, // Response strobe.
  input  wire ilr_pkg::ilr_rsp_s rsp_i,       // Response contents.
  input  wire logic              no_ack_i,    // Acknowledge withheld.
  output logic                   req_valid_o, // Access strobe.
  output ilr_pkg::ilr_req_s      req_o        // Access request.
);
  // The bus starts idle.
  initial
  begin
    req_valid_o = 1'b0;
    req_o = '0;
  end

  // One access: a one cycle strobe, the answer is taken one edge later.
  task automatic access(input logic wr, input logic [7:0] a,
    input logic [7:0] d, output logic got, output logic na,
    output ilr_pkg::ilr_rsp_s rsp);
    @(posedge clock_i);
    #1;
    req_valid_o = 1'b1;
    req_o = '{write: wr, addr: a, wdata: d};
    #1;
    na = no_ack_i;
    @(posedge clock_i);
    #1;
    got = rsp_valid_i;
    rsp = rsp_i;
    req_valid_o = 1'b0;
    // Released request lines show inverted values, never stale ones.
    req_o = ~req_o;
  endtask

  // Three key writes in order; upper bits are kept as given.
  task automatic key_seq(input logic [7:0] hi, output logic got,
    output logic na);
    ilr_pkg::ilr_rsp_s rsp;
    access(1'b1, ilr_pkg::ADDR_WLC, {hi[7:2], ilr_pkg::KEY_STEP1}, got, na,
      rsp);
    access(1'b1, ilr_pkg::ADDR_WLC, {hi[7:2], ilr_pkg::KEY_STEP2}, got, na,
      rsp);
    access(1'b1, ilr_pkg::ADDR_WLC, {hi[7:2], ilr_pkg::KEY_STEP3}, got, na,
      rsp);
  endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the lock and soft reset register logic.
module tb_top;
  // One plain access and the data it should return.
  typedef struct packed {
    logic       w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } ilr_row_s;

  logic              clock_i = 1'b0;                  // System clock.
  logic              sys_rst_i = 1'b1;                // Reset, high.
  logic              ce_i = 1'b1;                     // Clock enable.
  logic              spi_mode_i = 1'b1;               // Interface mode.
  logic              data_tx_i = 1'b0;                // Data transmission.
  logic [7:0]        temp_i = 8'h5A;                  // Temperature.
  logic              sup_err_i = 1'b0;                // Supply error.
  logic              timer_zero_i = 1'b1;             // Timer at zero.
  logic [63:0]       user_regs_i = 64'h0123456789ABCDEF; // User registers.
  logic              selftest_req_i = 1'b0;           // Self-test request.
  logic              req_valid_i;                     // Access strobe.
  ilr_pkg::ilr_req_s req_i;                           // Access request.
  logic              rsp_valid_o;                     // Response strobe.
  ilr_pkg::ilr_rsp_s rsp_o;                           // Response.
  logic              no_ack_o;                        // No acknowledge.
  logic              hold_rsp_o;                      // Responses held.
  logic              user_wr_en_o;                    // Writes allowed.
  logic              lock_o;                          // Lock state.
  logic              sup_fault_o;                     // Supply flag.
  logic              chk_err_o;                       // Check mismatch.
  logic              selftest_start_o;                // Self-test granted.
  logic              soft_reset_o;                    // Soft reset pulse.
  logic              got;                             // Answer seen.
  logic              na;                              // No acknowledge seen.
  ilr_pkg::ilr_rsp_s rsp;                             // Answer taken.
  int                n_errors = 0;                    // Mismatches.
  int                compares = 0;                    // Comparisons.
  int                n_soft = 0;                      // Soft reset pulses.

  // Plain accesses, each with the data it must return.
  ilr_row_s rows [6] = '{
    '{1'b1, ilr_pkg::ADDR_WLC, 8'h08, 8'h08},
    '{1'b0, ilr_pkg::ADDR_WLC, 8'h00, 8'h08},
    '{1'b1, ilr_pkg::ADDR_WLC, 8'h0B, 8'h0B},
    '{1'b0, ilr_pkg::ADDR_WLC, 8'h00, 8'h08},
    '{1'b0, ilr_pkg::ADDR_CHIP_TEMP, 8'h00, 8'h5A},
    '{1'b0, 8'h33, 8'h00, 8'h00}};

  ilr_regs #(.USER_W(64)) i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .ce_i(ce_i), .spi_mode_i(spi_mode_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .data_tx_i(data_tx_i), .temp_i(temp_i),
    .sup_err_i(sup_err_i), .timer_zero_i(timer_zero_i),
    .user_regs_i(user_regs_i), .selftest_req_i(selftest_req_i),
    .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .no_ack_o(no_ack_o),
    .hold_rsp_o(hold_rsp_o), .user_wr_en_o(user_wr_en_o), .lock_o(lock_o),
    .sup_fault_o(sup_fault_o), .chk_err_o(chk_err_o),
    .selftest_start_o(selftest_start_o), .soft_reset_o(soft_reset_o));

  ilr_host_model i_host (.clock_i(clock_i), .rsp_valid_i(rsp_valid_o),
    .rsp_i(rsp_o), .no_ack_i(no_ack_o), .req_valid_o(req_valid_i),
    .req_o(req_i));

  // The clock toggles every half period of 5 ns.
  initial
  begin
    forever #5 clock_i = ~clock_i;
  end

  // Soft reset pulses are counted as they appear.
  always @(posedge clock_i)
  begin
    if (soft_reset_o === 1'b1)
      n_soft++;
  end

  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Compares a byte.
  task automatic chk_byte(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Compares a single flag.
  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_byte(nm, {7'h00, e}, {7'h00, g});
  endtask

  // Lets n edges pass, then moves just after the last one.
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // One access through the host model.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    i_host.access(w, a, d, got, na, rsp);
  endtask

  // A hang is cut short and counted as a mismatch.
  initial
  begin
    #200000;
    n_errors++;
    complete_run();
  end

  // Main sequence.
  initial
  begin
    cyc(3);
    chk_bit("lock in reset", 1'b0, lock_o);
    chk_bit("rsp in reset", 1'b0, rsp_valid_o);
    chk_byte("rsp data in reset", ilr_pkg::WLC_RST, rsp_o.data);
    cyc(2);
    sys_rst_i = 1'b0;
    acc(1'b1, ilr_pkg::ADDR_CHIP_TEMP, 8'hFF);
    foreach (rows[i])
    begin
      acc(rows[i].w, rows[i].a, rows[i].d);
      chk_bit("rsp valid", 1'b1, got);
      chk_byte("rsp data", rows[i].e, rsp.data);
    end
    // Disable bit set: silent while timer runs, flag clears at zero.
    sup_err_i = 1'b1;
    timer_zero_i = 1'b0;
    acc(1'b0, ilr_pkg::ADDR_WLC, 8'h00);
    chk_bit("silent while timer", 1'b0, got);
    chk_bit("hold while timer", 1'b1, hold_rsp_o);
    sup_err_i = 1'b0;
    cyc(2);
    chk_bit("fault held", 1'b1, sup_fault_o);
    timer_zero_i = 1'b1;
    cyc(2);
    chk_bit("fault auto clear", 1'b0, sup_fault_o);
    chk_bit("hold released", 1'b0, hold_rsp_o);
    // Disable bit clear: one error code, clear by read or transmission.
    acc(1'b1, ilr_pkg::ADDR_WLC, 8'h00);
    sup_err_i = 1'b1;
    timer_zero_i = 1'b0;
    acc(1'b0, ilr_pkg::ADDR_WLC, 8'h00);
    chk_bit("no response", 1'b0, got);
    sup_err_i = 1'b0;
    cyc(1);
    timer_zero_i = 1'b1;
    acc(1'b0, ilr_pkg::ADDR_WLC, 8'h00);
    chk_bit("error code first", 1'b1, rsp.err_code);
    acc(1'b0, ilr_pkg::ADDR_WLC, 8'h00);
    chk_bit("error code once", 1'b0, rsp.err_code);
    chk_bit("fault kept", 1'b1, sup_fault_o);
    acc(1'b0, ilr_pkg::ADDR_SUPPLY_FAULT, 8'h00);
    cyc(1);
    chk_bit("fault read clear", 1'b0, sup_fault_o);
    sup_err_i = 1'b1;
    timer_zero_i = 1'b0;
    cyc(1);
    sup_err_i = 1'b0;
    data_tx_i = 1'b1;
    cyc(1);
    data_tx_i = 1'b0;
    cyc(1);
    chk_bit("tx with timer", 1'b1, sup_fault_o);
    timer_zero_i = 1'b1;
    data_tx_i = 1'b1;
    cyc(1);
    data_tx_i = 1'b0;
    cyc(1);
    chk_bit("tx clear", 1'b0, sup_fault_o);
    // Lock: writes frozen except keys, self-test refused, check runs.
    selftest_req_i = 1'b1;
    cyc(1);
    chk_bit("selftest open", 1'b1, selftest_start_o);
    acc(1'b1, ilr_pkg::ADDR_WLC, 8'h80);
    chk_byte("lock write", 8'h80, rsp.data);
    chk_bit("lock", 1'b1, lock_o);
    chk_bit("user writes", 1'b0, user_wr_en_o);
    chk_bit("selftest shut", 1'b0, selftest_start_o);
    acc(1'b1, ilr_pkg::ADDR_WLC, 8'h09);
    chk_byte("locked write", 8'h81, rsp.data);
    chk_bit("lock kept", 1'b1, lock_o);
    cyc(4);
    acc(1'b1, ilr_pkg::ADDR_WLC, 8'h83);
    cyc(4);
    chk_bit("keys not checked", 1'b0, chk_err_o);
    user_regs_i[9] = ~user_regs_i[9];
    cyc(4);
    chk_bit("check mismatch", 1'b1, chk_err_o);
    // Wrong orders and a read in mid-sequence give no reset.
    acc(1'b1, ilr_pkg::ADDR_WLC, 8'h83);
    acc(1'b1, ilr_pkg::ADDR_WLC, 8'h80);
    acc(1'b1, ilr_pkg::ADDR_WLC, 8'h82);
    acc(1'b1, ilr_pkg::ADDR_WLC, 8'h80);
    acc(1'b1, ilr_pkg::ADDR_WLC, 8'h83);
    acc(1'b0, ilr_pkg::ADDR_WLC, 8'h00);
    chk_byte("read keys", 8'h80, rsp.data);
    acc(1'b1, ilr_pkg::ADDR_WLC, 8'h82);
    cyc(3);
    chk_byte("no soft reset", 8'h00, n_soft[7:0]);
    // Exact key sequence resets the device.
    i_host.key_seq(8'h80, got, na);
    chk_bit("third no rsp", 1'b0, got);
    chk_bit("third no ack", 1'b1, na);
    cyc(2);
    chk_byte("soft resets", 8'h01, n_soft[7:0]);
    chk_bit("lock cleared", 1'b0, lock_o);
    chk_bit("check cleared", 1'b0, chk_err_o);
    // Clock enable low freezes all state, so this write is lost.
    ce_i = 1'b0;
    acc(1'b1, ilr_pkg::ADDR_WLC, 8'h80);
    chk_bit("frozen rsp", 1'b0, got);
    chk_bit("frozen lock", 1'b0, lock_o);
    ce_i = 1'b1;
    // Two-wire mode: silent until expiry, cleared only by read.
    spi_mode_i = 1'b0;
    sup_err_i = 1'b1;
    timer_zero_i = 1'b0;
    acc(1'b0, ilr_pkg::ADDR_WLC, 8'h00);
    chk_bit("silent two-wire", 1'b0, got);
    sup_err_i = 1'b0;
    timer_zero_i = 1'b1;
    data_tx_i = 1'b1;
    cyc(1);
    data_tx_i = 1'b0;
    cyc(2);
    chk_bit("two-wire kept", 1'b1, sup_fault_o);
    acc(1'b0, ilr_pkg::ADDR_SUPPLY_FAULT, 8'h00);
    cyc(1);
    chk_bit("two-wire clear", 1'b0, sup_fault_o);
    complete_run();
  end
endmodule
